/* File: core/ists_idle_sched.sv */
// Idle, standby and periodic task scheduler with host clock and select timing
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Command 0x03 enters idle, 0x04 returns to idle from any activity.
// - Options A bits 2:1 choose the state taken after power-on reset.
// - Options A bit 0 keeps the system clock running in standby.
// - Options B bits 1:0 choose the system clock frequency.
// - Standby may drive the system clock; idle stops it.
// - A 10 kHz slow time base drives sniff, burst and housekeeping timers.
// - Clock restarts to host after a valid packet or waking housekeeping.
// - Host writes return-to-idle after activities finish; device re-enters idle.
// - Idle config bits 0,1,2 enable sniff, burst, housekeeping; housekeeping runs only with sniff and ID check off.
// - Host interrupt marks data ready; active-low select starts transfer later.
// - Idle config bits 7:5 set interrupt-to-select delay after a valid packet, 111 is 8 bits.
// - Idle config bits 4:3 set 1024/512/256/0 clocks before shutdown.
// - Periodic housekeeping wakes for calibration or host wake-up.
// - Periodic burst wakes, transmits, then sleeps again.
// - Sniff wakes to check energy; on energy switches to full receive.
// - With ID check, missing valid identifier sends receiver back to sleep.
// - Receive config bit 1 hides clock and data below the energy threshold.
// - Receive config bit 0 wakes on energy reaching the programmed threshold.
// - Sniff interval sets the sleep period between receiver wake-ups.
// - Energy dwell sets how long each sniff wake-up listens for energy.
// - Code dwell limits the identifier search after energy detection.
// - False wake-ups are counted to track the noise level.
// - Sniff period is interval times 100 ms or 500 us resolution.
// - Threshold rises above target false wakes, falls below target.
module ists_idle_sched #(
   parameter int SLOW_DIV = ists_pkg::SLOW_TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire ists_pkg::ists_rf_in_t rfIn,
   output ists_pkg::ists_rf_out_t rfOut,
   output logic sysClockOutputPin,
   output logic dataTransferSelect_n,
   output logic hostInterrupt,
   output logic busy
);
   import ists_pkg::*;

   typedef struct packed {
      ists_state_t st;
      logic por;
      ists_regs_t regs;
      logic [7:0] rdata;
      logic [2:0][7:0] tCnt;
      logic [2:0] pend;
      logic [7:0] dwell;
      logic [9:0] cyc, fw;
      logic [10:0] stopCnt;
      logic sys_clock_output_pin;
      logic [2:0] sysDiv;
      logic [3:0] dssnCnt;
      logic dssnAct, hostInt;
   } ists_core_t;

   ists_core_t s, n;
   logic slowTick, fineTick, coarseTick;
   logic energyHit, clkRun, cmdHit, inSched, isBusy;
   logic [2:0] taskTick;
   logic [2:0][7:0] period;
   logic [3:0] dssnDelay;
   logic [9:0] atcN;
   logic [10:0] stopLoad;
   logic [2:0] halfLoad;

   if (SLOW_DIV < 2) begin : g_chk
      $error("ists_idle_sched: SLOW_DIV below 2");
   end

   // ===================================================
   // Time bases
   // slow oscillator tick
   ists_tick_div #(.DIV(SLOW_DIV)) u_slow (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .enable(1'b1),
      .tick(slowTick)
   );
   ists_tick_div #(.DIV(RES_FINE_TICKS)) u_fine (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .enable(slowTick),
      .tick(fineTick)
   );
   ists_tick_div #(.DIV(RES_COARSE_TICKS)) u_coarse (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .enable(slowTick),
      .tick(coarseTick)
   );

   // ===================================================
   // Decodes
   always_comb begin
      energyHit = s.regs.rxCfg[RX_WAKE_THR] ? (rfIn.energyLevel >= s.regs.thr)
                                            : rfIn.energyDetect;
      // sniff interval uses the selected resolution
      taskTick[TK_SNIFF] = s.regs.sniffCfg[SC_RES] ? coarseTick : fineTick;
      taskTick[TK_BURST] = coarseTick;
      taskTick[TK_HK] = coarseTick;
      period[TK_SNIFF] = s.regs.sniffInt;
      period[TK_BURST] = s.regs.burstInt;
      period[TK_HK] = s.regs.hkInt;
      // 111 gives 8 bit times, 000 none
      if (s.regs.idleCfg[IC_DATA_TRANSFER_SELECT_N_LSB +: 3] == 3'h0) begin
         dssnDelay = 4'h0;
      end else begin
         dssnDelay = {1'b0, s.regs.idleCfg[IC_DATA_TRANSFER_SELECT_N_LSB +: 3]} + 4'h1;
      end
      // clocks granted after the idle command
      unique case (s.regs.idleCfg[IC_STOP_LSB +: 2])
         2'b11: stopLoad = STOP_CYC_1024;
         2'b10: stopLoad = STOP_CYC_512;
         2'b01: stopLoad = STOP_CYC_256;
         2'b00: stopLoad = 11'h000;
      endcase
      unique case (s.regs.sniffCfg[SC_ATC_LSB +: 2])
         2'b11: atcN = ATC_CYC_100;
         2'b10: atcN = ATC_CYC_500;
         2'b01: atcN = ATC_CYC_100;
         2'b00: atcN = 10'h000;
      endcase
      // half period of 1, 2, 4 or 8 reference cycles
      halfLoad = 3'((4'h1 << s.regs.genB[GB_FREQ_LSB +: 2]) - 4'h1);
      // clock runs awake, in standby if asked, in grace
      clkRun = (s.st == ST_ACTIVE) || (s.st == ST_WAKE) || (s.stopCnt != 11'h000)
               || ((s.st == ST_STANDBY) && s.regs.genA[GA_SYS_CLOCK_OUTPUT_PIN_STBY]);
      cmdHit = regWrite && (regAddr == OFF_CMD)
               && ((regWdata == CMD_IDLE_ENTER) || (regWdata == CMD_IDLE_RETURN));
      inSched = (s.st != ST_ACTIVE) && (s.st != ST_STANDBY);
      isBusy = (s.st == ST_SNIFF) || (s.st == ST_CODE) || (s.st == ST_RECV)
               || (s.st == ST_BURST);
   end

   // ===================================================
   // Next state
   always_comb begin
      n = s;
      n.rdata = 8'h00;
      n.por = 1'b0;
      if (regWrite) begin
         case (regAddr)
            OFF_GEN_A: n.regs.genA = regWdata;
            OFF_GEN_B: n.regs.genB = regWdata;
            OFF_RX_CFG: n.regs.rxCfg = regWdata;
            OFF_IDLE_CFG: n.regs.idleCfg = regWdata;
            OFF_SNIFF_CFG: n.regs.sniffCfg = regWdata;
            OFF_SNIFF_INT: n.regs.sniffInt = regWdata;
            OFF_E_DWELL: n.regs.eDwell = regWdata;
            OFF_C_DWELL: n.regs.cDwell = regWdata;
            OFF_BURST_INT: n.regs.burstInt = regWdata;
            OFF_HK_INT: n.regs.hkInt = regWdata;
            OFF_FW_TARGET: n.regs.fwTarget = regWdata;
            OFF_E_THRESH: n.regs.thr = regWdata;
            OFF_TASK_OPT: n.regs.taskOpt = regWdata;
            default: ;
         endcase
      end
      if (regRead) begin
         case (regAddr)
            OFF_STATUS2: n.rdata = {4'h0, clkRun, s.dssnAct, s.hostInt, isBusy};
            OFF_GEN_A: n.rdata = s.regs.genA;
            OFF_GEN_B: n.rdata = s.regs.genB;
            OFF_RX_CFG: n.rdata = s.regs.rxCfg;
            OFF_IDLE_CFG: n.rdata = s.regs.idleCfg;
            OFF_SNIFF_CFG: n.rdata = s.regs.sniffCfg;
            OFF_SNIFF_INT: n.rdata = s.regs.sniffInt;
            OFF_E_DWELL: n.rdata = s.regs.eDwell;
            OFF_C_DWELL: n.rdata = s.regs.cDwell;
            OFF_BURST_INT: n.rdata = s.regs.burstInt;
            OFF_HK_INT: n.rdata = s.regs.hkInt;
            OFF_FW_TARGET: n.rdata = s.regs.fwTarget;
            OFF_E_THRESH: n.rdata = s.regs.thr;
            OFF_TASK_OPT: n.rdata = s.regs.taskOpt;
            default: n.rdata = 8'h00;
         endcase
      end

      unique case (s.st)
         ST_ACTIVE, ST_STANDBY: ;
         ST_IDLE: begin
            if (s.pend[TK_SNIFF]) begin
               n.pend[TK_SNIFF] = 1'b0;
               n.st = ST_SNIFF;
               n.dwell = s.regs.eDwell;
               n.cyc = s.cyc + 10'h001;
               // adjust after the counted window of sniff cycles
               if ((atcN != 10'h000) && (n.cyc >= atcN)) begin
                  if ((s.fw > {2'b00, s.regs.fwTarget}) && (s.regs.thr != 8'hff)) begin
                     n.regs.thr = s.regs.thr + 8'h01;
                  end else if ((s.fw < {2'b00, s.regs.fwTarget}) && (s.regs.thr != 8'h00)) begin
                     n.regs.thr = s.regs.thr - 8'h01;
                  end
                  n.cyc = 10'h000;
                  n.fw = 10'h000;
               end
            end else if (s.pend[TK_BURST]) begin
               n.pend[TK_BURST] = 1'b0;
               n.st = ST_BURST;
            end else if (s.pend[TK_HK]) begin
               n.pend[TK_HK] = 1'b0;
               // housekeeping runs in the identifier search state
               n.st = ST_CODE;
               n.dwell = 8'h00;
            end
         end
         ST_SNIFF: begin
            // energy found switches to full receive, or to the identifier search with ID check
            if (energyHit) begin
               n.st = s.regs.taskOpt[TO_ID_CHECK] ? ST_CODE : ST_RECV;
               n.dwell = s.regs.cDwell;
            end else if (slowTick) begin
               if (s.dwell == 8'h00) begin
                  n.st = ST_IDLE;
               end else begin
                  n.dwell = s.dwell - 8'h01;
               end
            end
         end
         ST_CODE: begin
            if (rfOut.hkEnable) begin
               if (rfIn.hkDone) begin
                  n.st = s.regs.taskOpt[TO_HK_WAKE] ? ST_WAKE : ST_IDLE;
                  n.hostInt = s.regs.taskOpt[TO_HK_WAKE];
                  n.dssnAct = s.regs.taskOpt[TO_HK_WAKE];
               end
            end else if (rfIn.idValid) begin
               n.st = ST_RECV;
            end else if (slowTick) begin
               // no identifier in time, back to sleep
               if (s.dwell == 8'h00) begin
                  n.st = ST_IDLE;
                  n.fw = s.fw + 10'h001;
               end else begin
                  n.dwell = s.dwell - 8'h01;
               end
            end
         end
         ST_RECV: begin
            if (rfIn.packetValid) begin
               // data ready raises the host interrupt
               n.st = ST_WAKE;
               n.hostInt = 1'b1;
               n.dssnCnt = dssnDelay;
               n.dssnAct = (dssnDelay == 4'h0);
            end else if (rfIn.packetFail) begin
               n.st = ST_IDLE;
               n.fw = s.fw + 10'h001;
            end
         end
         ST_BURST: begin
            if (rfIn.txDone) begin
               n.st = ST_IDLE;
            end
         end
         ST_WAKE: begin
            // select goes low once the delay expires
            if (!s.dssnAct) begin
               if (s.dssnCnt == 4'h0) begin
                  n.dssnAct = 1'b1;
               end else if (rfIn.bitTick) begin
                  n.dssnCnt = s.dssnCnt - 4'h1;
               end
            end
         end
         default: n.st = ST_IDLE;
      endcase

      if (s.por) begin
         unique case (s.regs.genA[GA_POR_LSB +: 2])
            POR_IDLE: n.st = ST_IDLE;
            POR_ACTIVE: n.st = ST_ACTIVE;
            default: n.st = ST_STANDBY;
         endcase
      end

      // host command forces idle from anywhere
      if (cmdHit) begin
         n.st = ST_IDLE;
         n.hostInt = 1'b0;
         n.dssnAct = 1'b0;
         n.dssnCnt = 4'h0;
         n.stopCnt = stopLoad;
      end

      // Set after the FSM's clears so a coinciding expiry is kept
      for (int i = 0; i < 3; i++) begin
         if (!s.regs.idleCfg[i] || !inSched
             || (cmdHit && (regWdata == CMD_IDLE_ENTER))) begin
            n.pend[i] = 1'b0;
            n.tCnt[i] = period[i];
         end else if (taskTick[i]) begin
            if (s.tCnt[i] == 8'h00) begin
               n.pend[i] = 1'b1;
               n.tCnt[i] = period[i];
            end else begin
               n.tCnt[i] = s.tCnt[i] - 8'h01;
            end
         end
      end

      // system clock divider, forced low when stopped
      if (clkRun) begin
         if (s.sysDiv == 3'h0) begin
            n.sys_clock_output_pin = !s.sys_clock_output_pin;
            n.sysDiv = halfLoad;
            // Count on falling edges so the pin ends low
            // A fresh command reload must not be eaten by this decrement
            if (s.sys_clock_output_pin && (s.st == ST_IDLE) && (s.stopCnt != 11'h000) && !cmdHit) begin
               n.stopCnt = s.stopCnt - 11'h001;
            end
         end else begin
            n.sysDiv = s.sysDiv - 3'h1;
         end
      end else begin
         n.sys_clock_output_pin = 1'b0;
         n.sysDiv = 3'h0;
      end
      if (n.st != ST_IDLE) begin
         n.stopCnt = 11'h000;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.st <= ST_STANDBY;
         s.por <= 1'b1;
         s.regs <= REGS_RST;
      end else begin
         s <= n;
      end
   end

   // ===================================================
   // Outputs
   always_comb begin
      rfOut.hkEnable = (s.st == ST_CODE) && !s.regs.taskOpt[TO_ID_CHECK]
                       && !s.regs.idleCfg[TK_SNIFF] ? 1'b1 : 1'b0;
      rfOut.rxEnable = (s.st == ST_SNIFF) || (s.st == ST_RECV)
                       || ((s.st == ST_CODE) && (s.dwell != 8'h00 || !rfOut.hkEnable));
      rfOut.rxDataEnable = rfOut.rxEnable && !(s.regs.rxCfg[RX_QUIET] && !energyHit);
      rfOut.txEnable = (s.st == ST_BURST);
      rfOut.energyThreshold = s.regs.thr;
   end
   assign regRdata = s.rdata;
   assign sysClockOutputPin = s.sys_clock_output_pin;
   assign dataTransferSelect_n = !s.dssnAct;
   assign hostInterrupt = s.hostInt;
   assign busy = isBusy;

   // ===================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence sniffHit;
      (s.st == ST_SNIFF) && energyHit && !s.regs.taskOpt[TO_ID_CHECK] && !s.por && !cmdHit;
   endsequence
   sequence idleSettled;
      (s.st == ST_IDLE) && (s.stopCnt == 11'h000) ##1 (s.st == ST_IDLE);
   endsequence
   cmd_idle_a: assert property (cmdHit |=> (s.st == ST_IDLE))
      else $error("idle command not taken");
   por_state_a: assert property (s.por && (s.regs.genA[2:1] == POR_IDLE) |=> s.st == ST_IDLE)
      else $error("power-on state wrong");
   stby_clk_a: assert property ((s.st == ST_STANDBY) && s.regs.genA[0] && !s.por
                                |-> ##[1:17] $changed(sysClockOutputPin))
      else $error("standby clock not running");
   idle_noclk_a: assert property (idleSettled |-> !sysClockOutputPin)
      else $error("clock running in idle");
   sniff_rx_a: assert property (sniffHit |=> (s.st == ST_RECV))
      else $error("energy did not start receive");
   burst_done_a: assert property ((s.st == ST_BURST) && rfIn.txDone && !s.por |=> s.st == ST_IDLE)
      else $error("burst did not return to idle");
   data_transfer_select_n_int_a: assert property (!dataTransferSelect_n |-> hostInterrupt)
      else $error("select without interrupt");
   data_transfer_select_n_now_a: assert property ($rose(hostInterrupt) && (dssnDelay == 4'h0)
                                |-> !dataTransferSelect_n)
      else $error("zero delay select late");
   quiet_rx_a: assert property (s.regs.rxCfg[1] && !energyHit |-> !rfOut.rxDataEnable)
      else $error("data out below threshold");
   busy_idle_a: assert property ((s.st == ST_IDLE) || (s.st == ST_STANDBY) |-> !busy)
      else $error("busy in low power");
endmodule
`default_nettype wire

/* File: core/ists_pkg.sv */
// Constants, register map and carrier types of the idle task scheduler
package ists_pkg;
   // ===================================================
   // Timing
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int SLOW_OSC_HZ = 10_000;
   localparam int SLOW_TICK_CYC = REF_CLK_HZ / SLOW_OSC_HZ;
   localparam int RES_FINE_US = 500;
   localparam int RES_COARSE_MS = 100;
   localparam int RES_FINE_TICKS = RES_FINE_US * SLOW_OSC_HZ / 1_000_000;
   localparam int RES_COARSE_TICKS = RES_COARSE_MS * SLOW_OSC_HZ / 1_000;
   localparam logic [10:0] STOP_CYC_256 = 11'h100;
   localparam logic [10:0] STOP_CYC_512 = 11'h200;
   localparam logic [10:0] STOP_CYC_1024 = 11'h400;
   localparam logic [9:0] ATC_CYC_100 = 10'h064;
   localparam logic [9:0] ATC_CYC_500 = 10'h1f4;
   // ===================================================
   // Register offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_STATUS2 = 8'h02;
   localparam logic [7:0] OFF_GEN_A = 8'h0c;
   localparam logic [7:0] OFF_GEN_B = 8'h0d;
   localparam logic [7:0] OFF_RX_CFG = 8'h0e;
   localparam logic [7:0] OFF_IDLE_CFG = 8'h10;
   localparam logic [7:0] OFF_SNIFF_CFG = 8'h11;
   localparam logic [7:0] OFF_SNIFF_INT = 8'h12;
   localparam logic [7:0] OFF_E_DWELL = 8'h13;
   localparam logic [7:0] OFF_C_DWELL = 8'h20;
   localparam logic [7:0] OFF_BURST_INT = 8'h21;
   localparam logic [7:0] OFF_HK_INT = 8'h22;
   localparam logic [7:0] OFF_FW_TARGET = 8'h23;
   localparam logic [7:0] OFF_E_THRESH = 8'h24;
   localparam logic [7:0] OFF_TASK_OPT = 8'h25;
   localparam logic [7:0] CMD_IDLE_ENTER = 8'h03;
   localparam logic [7:0] CMD_IDLE_RETURN = 8'h04;
   // ===================================================
   // Field positions
   localparam int GA_SYS_CLOCK_OUTPUT_PIN_STBY = 0;
   localparam int GA_POR_LSB = 1;
   localparam int GB_FREQ_LSB = 0;
   localparam int RX_WAKE_THR = 0;
   localparam int RX_QUIET = 1;
   localparam int TK_SNIFF = 0;
   localparam int TK_BURST = 1;
   localparam int TK_HK = 2;
   localparam int IC_STOP_LSB = 3;
   localparam int IC_DATA_TRANSFER_SELECT_N_LSB = 5;
   localparam int SC_RES = 0;
   localparam int SC_ATC_LSB = 3;
   localparam int TO_ID_CHECK = 0;
   localparam int TO_HK_WAKE = 1;
   localparam int S2_BUSY = 0;
   localparam int S2_INT = 1;
   localparam int S2_DATA_TRANSFER_SELECT_N = 2;
   localparam int S2_CLK = 3;
   localparam logic [1:0] POR_STANDBY = 2'b00;
   localparam logic [1:0] POR_IDLE = 2'b01;
   localparam logic [1:0] POR_ACTIVE = 2'b10;
   // ===================================================
   // Types
   typedef enum logic [7:0] {
      ST_ACTIVE = 8'h01, ST_STANDBY = 8'h02, ST_IDLE = 8'h04, ST_SNIFF = 8'h08,
      ST_CODE = 8'h10, ST_RECV = 8'h20, ST_BURST = 8'h40, ST_WAKE = 8'h80
   } ists_state_t;
   typedef struct packed {
      logic [7:0] genA, genB, rxCfg, idleCfg, sniffCfg, sniffInt, eDwell;
      logic [7:0] cDwell, burstInt, hkInt, fwTarget, thr, taskOpt;
   } ists_regs_t;
   localparam logic [7:0] REG_ZERO_RST = 8'h00;
   localparam logic [7:0] E_THRESH_RST = 8'h40;
   localparam ists_regs_t REGS_RST = '{thr: E_THRESH_RST, default: REG_ZERO_RST};
   typedef struct packed {
      logic [7:0] energyLevel;
      logic energyDetect, idValid, packetValid, packetFail;
      logic txDone, hkDone, bitTick;
   } ists_rf_in_t;
   typedef struct packed {
      logic rxEnable, rxDataEnable, txEnable, hkEnable;
      logic [7:0] energyThreshold;
   } ists_rf_out_t;
endpackage

/* File: core/ists_tick_div.sv */
// Enable-pulse divider for the slow time bases
`timescale 1ns/10ps
`default_nettype none
module ists_tick_div #(
   parameter int DIV = 1000
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic enable,
   output logic tick
);
   localparam int W = $clog2(DIV);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } ists_div_t;
   ists_div_t s, n;

   if (DIV < 2) begin : g_chk
      $error("ists_tick_div: DIV below 2");
   end

   always_comb begin
      n = s;
      n.tick = 1'b0;
      if (enable) begin
         if (s.cnt == W'(DIV - 1)) begin
            n.cnt = '0;
            n.tick = 1'b1;
         end else begin
            n.cnt = s.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tick = s.tick;
endmodule
`default_nettype wire

/* File: dv/ists_rf_model.sv */
// Behavioural radio front end facing the scheduler's rf ports
`timescale 1ns/10ps
`default_nettype none
module ists_rf_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire ists_pkg::ists_rf_out_t rfOut,
   output ists_pkg::ists_rf_in_t rfIn
);
   import ists_pkg::*;
   logic [3:0] cnt;
   logic [1:0] bitCnt;
   logic en;
   assign en = rfOut.rxEnable | rfOut.rxDataEnable | rfOut.txEnable | rfOut.hkEnable;
   // ===================================================
   // Answers a few cycles after each enable, bit time every 4 cycles
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 4'h0;
         bitCnt <= 2'h0;
         rfIn <= '0;
      end else begin
         bitCnt <= bitCnt + 2'h1;
         cnt <= !en ? 4'h0 : (cnt == 4'hf) ? cnt : cnt + 4'h1;
         rfIn.bitTick <= (bitCnt == 2'h3);
         rfIn.energyDetect <= rfOut.rxEnable && (cnt >= 4'h2);
         // Packet stays valid while receive stays enabled, as a held receive result
         rfIn.packetValid <= (rfOut.rxEnable | rfOut.rxDataEnable) && (cnt >= 4'h8);
         rfIn.txDone <= rfOut.txEnable && (cnt == 4'h3);
         rfIn.hkDone <= rfOut.hkEnable && (cnt == 4'h3);
      end
   end
endmodule
`default_nettype wire

/* File: dv/ists_idle_sched_tb.sv */
// Self-checking bench for the idle task scheduler
`timescale 1ns/10ps
`default_nettype none
module ists_idle_sched_tb;
   import ists_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata;
   ists_rf_in_t rfIn;
   ists_rf_out_t rfOut;
   logic sys_clock_output_pin, dataSelect_n, hostInt, busy;
   int error_cnt = 0;
   int n_compared = 0;
   int clkFalls = 0;
   int bitTicks = 0;
   int f0, b, i;
   initial forever #50 ref_clk = ~ref_clk;
   always @(negedge sys_clock_output_pin) clkFalls++;
   always @(posedge ref_clk) if (rfIn.bitTick === 1'b1) bitTicks++;
   ists_idle_sched #(.SLOW_DIV(4)) u_ists_idle_sched (.ref_clk(ref_clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .rfIn(rfIn), .rfOut(rfOut), .sysClockOutputPin(sys_clock_output_pin),
      .dataTransferSelect_n(dataSelect_n), .hostInterrupt(hostInt), .busy(busy));
   ists_rf_model u_ists_rf_model (.ref_clk(ref_clk), .reset_n(reset_n), .rfOut(rfOut),
      .rfIn(rfIn));
   // ===================================================
   // Bus and compare helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      chk({8'h00, regRdata}, {8'h00, exp});
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ===================================================
   // Scenarios
   task automatic test_regs_clock;
      rd(OFF_E_THRESH, 8'h40);
      chk(16'(rfOut.energyThreshold), 16'h40);
      rd(8'h30, 8'h00);
      rd(OFF_GEN_A, 8'h00);
      chk(16'(busy), 16'h0);
      chk(16'(sys_clock_output_pin), 16'h0);
      wr(OFF_IDLE_CFG, 8'h5a);
      rd(OFF_IDLE_CFG, 8'h5a);
      wr(OFF_GEN_A, 8'h01);
      for (i = 0; i < 4; i++) begin
         wr(OFF_GEN_B, 8'(i));
         repeat (40) @(posedge ref_clk);
         f0 = clkFalls;
         repeat (160) @(posedge ref_clk);
         chk(16'(clkFalls - f0), 16'(160 >> (i + 1)));
      end
      wr(OFF_GEN_A, 8'h00);
      repeat (40) @(posedge ref_clk);
      f0 = clkFalls;
      repeat (40) @(posedge ref_clk);
      chk(16'(clkFalls - f0), 16'h0);
      $display("test regs_clock done");
   endtask
   task automatic test_burst;
      wr(OFF_BURST_INT, 8'h00);
      wr(OFF_IDLE_CFG, 8'h02);
      wr(OFF_CMD, CMD_IDLE_ENTER);
      #1;
      chk(16'(sys_clock_output_pin), 16'h0);
      for (i = 0; i < 6000 && busy !== 1'b1; i++) @(posedge ref_clk);
      #1;
      chk(16'(busy), 16'h1);
      chk(16'(rfOut.txEnable), 16'h1);
      for (i = 0; i < 50 && busy !== 1'b0; i++) @(posedge ref_clk);
      #1;
      chk(16'(rfOut.txEnable), 16'h0);
      rd(OFF_STATUS2, 8'h00);
      $display("test burst done");
   endtask
   task automatic test_sniff;
      // Fast clock keeps the grace count short; dwell outlasts the first slow tick
      wr(OFF_GEN_B, 8'h00);
      wr(OFF_E_DWELL, 8'h02);
      wr(OFF_IDLE_CFG, 8'he9);
      wr(OFF_CMD, CMD_IDLE_ENTER);
      // Poll after each edge has settled so tick counts line up
      for (i = 0; i < 1000 && hostInt !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      b = bitTicks;
      f0 = clkFalls;
      chk(16'(hostInt), 16'h1);
      chk(16'(dataSelect_n), 16'h1);
      for (i = 0; i < 200 && dataSelect_n !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk(16'(bitTicks - b), 16'h8);
      chk(16'(clkFalls > f0), 16'h1);
      wr(OFF_IDLE_CFG, 8'he8);
      @(posedge ref_clk);
      regAddr <= OFF_CMD;
      regWdata <= CMD_IDLE_RETURN;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      #1;
      f0 = clkFalls;
      @(posedge ref_clk);
      #1;
      chk(16'(hostInt), 16'h0);
      chk(16'(dataSelect_n), 16'h1);
      repeat (700) @(posedge ref_clk);
      chk(16'(clkFalls - f0), 16'd256);
      chk(16'(sys_clock_output_pin), 16'h0);
      $display("test sniff done");
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      test_regs_clock;
      test_burst;
      test_sniff;
      complete_run;
   end
   // Whole run needs about 5000 cycles
   initial begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      complete_run;
   end
endmodule
`default_nettype wire
